// ### csc_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none

module csc_bus_cycle (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Request from the sequencer
  input wire logic i_start,
  input wire csc_pkg::csc_breq_t i_req,
  output logic o_done,
  output logic [15:0] o_rdata,
  // Internal bus
  input wire logic [15:0] i_rdata,
  output var csc_pkg::csc_bus_t o_bus
);

  typedef struct packed {
    logic active;
    logic [1:0] cnt;
    logic [1:0] len;
    logic done;
    logic [15:0] rdata;
    csc_pkg::csc_bus_t bus;
  } csc_bc_state_t;

  csc_bc_state_t st_r;
  csc_bc_state_t st_nxt;
  logic periph_c;
  logic slow_c;

  assign periph_c = i_req.addr >= csc_pkg::IO_BASE;
  assign slow_c = (i_req.addr >= csc_pkg::SLOW0_LO &&
                   i_req.addr <= csc_pkg::SLOW0_HI) ||
                  (i_req.addr >= csc_pkg::SLOW1_LO &&
                   i_req.addr <= csc_pkg::SLOW1_HI);

  // ----------------------------------------------------------------
  // Cycle sequencing
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (!st_r.active) begin
      if (i_start) begin
        st_nxt.active = 1'b1;
        st_nxt.cnt = csc_pkg::STATE_FIRST;
        st_nxt.len = slow_c ? csc_pkg::STATES_SLOW
                            : csc_pkg::STATES_FAST; // see RQ11
        // Address, strobe and data all appear in the first state
        st_nxt.bus.addr = i_req.addr; // see RQ20
        st_nxt.bus.wdata = i_req.word ? i_req.wdata
                         : {i_req.wdata[7:0], i_req.wdata[7:0]};
        st_nxt.bus.rd = !i_req.we;
        st_nxt.bus.wr = i_req.we;
        // Peripherals have an 8-bit path, so words are cut to bytes
        st_nxt.bus.word = i_req.word && !periph_c; // see RQ12, RQ13
        st_nxt.bus.periph = periph_c;
      end
    end else if (st_r.cnt == st_r.len) begin
      st_nxt.active = 1'b0;
      st_nxt.done = 1'b1;
      st_nxt.bus.rd = 1'b0;
      st_nxt.bus.wr = 1'b0;
      if (st_r.bus.word) begin
        st_nxt.rdata = i_rdata;
      end else if (st_r.bus.periph || st_r.bus.addr[0]) begin
        st_nxt.rdata = {8'h00, i_rdata[7:0]};
      end else begin
        st_nxt.rdata = {8'h00, i_rdata[15:8]};
      end
    end else begin
      st_nxt.cnt = st_r.cnt + 2'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_done = st_r.done;
  assign o_rdata = st_r.rdata;
  assign o_bus = st_r.bus;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  a_mem_states: assert property ( // see RQ12
    i_start && !st_r.active && !periph_c
    |=> (o_bus.rd || o_bus.wr)[*2] ##1 (o_done && !o_bus.rd && !o_bus.wr))
    else $error("memory cycle not two states");
  a_slow_states: assert property ( // see RQ13
    i_start && !st_r.active && slow_c
    |=> (o_bus.rd || o_bus.wr)[*3] ##1 o_done)
    else $error("slow peripheral cycle not three states");
  a_io_byte: assert property (o_bus.periph |-> !o_bus.word) // see RQ13
    else $error("word access on peripheral path");
  a_addr_hold: assert property ( // see RQ20
    (o_bus.rd || o_bus.wr) && $past(o_bus.rd || o_bus.wr)
    |-> $stable(o_bus.addr) && $stable(o_bus.wdata))
    else $error("address or data moved within a cycle");
  c_slow_cycle: cover property (i_start && !st_r.active && slow_c);

endmodule

`default_nettype wire

// ### csc_core.sv
// Functional notes
// RQ1: Exception return pops flags then PC and resumes the interrupted flow.
// RQ2: Power-down instruction moves the CPU into a chosen halt mode.
// RQ3: Flag load writes an immediate or a byte register into the flags.
// RQ4: Flag store copies the flags into a chosen byte register.
// RQ5: Flag AND replaces flags with flags AND immediate.
// RQ6: Flag OR replaces flags with flags OR immediate.
// RQ7: Flag XOR replaces flags with flags XOR immediate.
// RQ8: No-operation only advances the program counter by two.
// RQ9: Block copy moves bytes source to destination, bumping pointers, until zero.
// RQ10: Zero count copies nothing; afterwards the next instruction runs.
// RQ11: One state is one clock; bus cycles last two or three states.
// RQ12: Memory accesses take two states on a 16-bit path, byte or word.
// RQ13: Peripheral accesses take two or three states, byte only.
// RQ14: CPU is in reset, execution, halt or exception handling.
// RQ15: In execution the CPU fetches and executes instructions in order.
// RQ16: Active modes run on system clock, subactive on the subclock.
// RQ17: Halt offers high/medium sleep, standby, watch and subsleep.
// RQ18: Exception state is entered briefly on reset or interrupt.
// RQ19: Interrupt entry pushes PC and flags using the stack pointer.
// RQ20: Address, strobe and data stand from first to last state.
`timescale 1ns/1ps
`default_nettype none

module csc_core (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Internal bus
  input wire logic [15:0] i_bus_rdata,
  output var csc_pkg::csc_bus_t o_bus,
  // Interrupt request
  input wire logic i_irq_req,
  input wire logic [15:0] i_irq_vec,
  output logic o_irq_ack,
  // Operating mode
  input wire csc_pkg::csc_run_t i_run_mode,
  input wire csc_pkg::csc_halt_t i_halt_mode,
  output var csc_pkg::csc_cpu_t o_cpu_state,
  output var csc_pkg::csc_halt_t o_halt_mode,
  output logic o_clk_sub
);

  typedef struct packed {
    csc_pkg::csc_cpu_t cpu;
    csc_pkg::csc_step_t step;
    csc_pkg::csc_step_t ret;
    logic [15:0] pc;
    logic [7:0] flags;
    logic [7:0][15:0] regs;
    logic [15:0] vec;
    logic go;
    csc_pkg::csc_breq_t req;
    logic ack;
    csc_pkg::csc_halt_t hmode;
    logic clk_sub;
  } csc_core_state_t;

  csc_core_state_t st_r;
  csc_core_state_t st_nxt;
  logic bus_done;
  logic [15:0] bus_rdata;
  logic irq_take;
  logic [7:0] dop;
  logic [7:0] darg;

  assign irq_take = i_irq_req && !st_r.flags[csc_pkg::FLAG_MASK_BIT];
  assign dop = bus_rdata[15:8];
  assign darg = bus_rdata[7:0];

  function automatic logic [7:0] breg(input logic [7:0][15:0] r,
                                      input logic [3:0] idx);
    breg = idx[3] ? r[idx[2:0]][7:0] : r[idx[2:0]][15:8];
  endfunction

  function automatic csc_pkg::csc_breq_t mk_req(input logic [15:0] a,
                                                input logic [15:0] d,
                                                input logic we,
                                                input logic word);
    mk_req.addr = a;
    mk_req.wdata = d;
    mk_req.we = we;
    mk_req.word = word;
  endfunction

  // ----------------------------------------------------------------
  // Bus cycle unit
  // ----------------------------------------------------------------
  csc_bus_cycle u_bus (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_start(st_r.go),
    .i_req(st_r.req),
    .o_done(bus_done),
    .o_rdata(bus_rdata),
    .i_rdata(i_bus_rdata),
    .o_bus(o_bus)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.go = 1'b0;
    st_nxt.ack = 1'b0;
    unique case (st_r.cpu)
      csc_pkg::CPU_RESET: begin
        // Reset vector fetch runs as a short exception pass
        st_nxt.cpu = csc_pkg::CPU_EXC; // see RQ14, RQ18
        st_nxt.step = csc_pkg::ST_VEC;
        st_nxt.vec = csc_pkg::VEC_RESET;
      end
      csc_pkg::CPU_HALT: begin
        // Only an accepted interrupt ends the halt
        if (irq_take) begin
          st_nxt.cpu = csc_pkg::CPU_EXC; // see RQ18
          st_nxt.step = csc_pkg::ST_PUSH_PC;
          st_nxt.vec = i_irq_vec;
          st_nxt.ack = 1'b1;
        end
      end
      csc_pkg::CPU_EXEC, csc_pkg::CPU_EXC: begin
        unique case (st_r.step)
          csc_pkg::ST_FETCH: begin
            st_nxt.clk_sub = i_run_mode == csc_pkg::RUN_SUBACTIVE; // see RQ16
            st_nxt.req = mk_req(st_r.pc, 16'h0000, 1'b0, 1'b1); // see RQ15
            st_nxt.pc = st_r.pc + csc_pkg::PC_STEP; // see RQ8
            st_nxt.go = 1'b1;
            st_nxt.step = csc_pkg::ST_WAIT;
            st_nxt.ret = csc_pkg::ST_DECODE;
          end
          csc_pkg::ST_WAIT: begin
            if (bus_done) begin
              st_nxt.step = st_r.ret;
            end
          end
          csc_pkg::ST_DECODE: begin
            st_nxt.step = csc_pkg::ST_NEXT;
            case (dop)
              csc_pkg::OP_SLEEP: begin
                st_nxt.cpu = csc_pkg::CPU_HALT; // see RQ2
                st_nxt.hmode = i_halt_mode; // see RQ17
                st_nxt.clk_sub = i_halt_mode == csc_pkg::HALT_SUBSLEEP;
              end
              csc_pkg::OP_FLAG_LOAD_IMM: st_nxt.flags = darg; // see RQ3
              csc_pkg::OP_FLAG_LOAD_REG: begin
                st_nxt.flags = breg(st_r.regs, darg[3:0]); // see RQ3
              end
              csc_pkg::OP_FLAG_STORE: begin
                if (darg[3]) begin
                  st_nxt.regs[darg[2:0]][7:0] = st_r.flags; // see RQ4
                end else begin
                  st_nxt.regs[darg[2:0]][15:8] = st_r.flags; // see RQ4
                end
              end
              csc_pkg::OP_FLAG_AND: begin
                st_nxt.flags = st_r.flags & darg; // see RQ5
              end
              csc_pkg::OP_FLAG_OR: begin
                st_nxt.flags = st_r.flags | darg; // see RQ6
              end
              csc_pkg::OP_FLAG_XOR: begin
                st_nxt.flags = st_r.flags ^ darg; // see RQ7
              end
              csc_pkg::OP_EXC_RETURN: begin
                st_nxt.req = mk_req(st_r.regs[csc_pkg::IDX_STACK], 16'h0000,
                                    1'b0, 1'b1); // see RQ1
                st_nxt.go = 1'b1;
                st_nxt.step = csc_pkg::ST_WAIT;
                st_nxt.ret = csc_pkg::ST_RET_FLAGS;
              end
              csc_pkg::OP_BLOCK_COPY: begin
                // A zero count skips straight to the next instruction
                if (st_r.regs[csc_pkg::IDX_CNT][7:0] != 8'h00) begin
                  st_nxt.step = csc_pkg::ST_MOV_RD; // see RQ9, RQ10
                end
              end
              // Unknown codes behave as no-operation
              default: st_nxt.step = csc_pkg::ST_NEXT; // see RQ8
            endcase
          end
          csc_pkg::ST_RET_FLAGS: begin
            st_nxt.flags = bus_rdata[15:8]; // see RQ1
            st_nxt.regs[csc_pkg::IDX_STACK] =
              st_r.regs[csc_pkg::IDX_STACK] + csc_pkg::WORD_STEP;
            st_nxt.req = mk_req(st_nxt.regs[csc_pkg::IDX_STACK], 16'h0000,
                                1'b0, 1'b1);
            st_nxt.go = 1'b1;
            st_nxt.step = csc_pkg::ST_WAIT;
            st_nxt.ret = csc_pkg::ST_RET_PC;
          end
          csc_pkg::ST_RET_PC: begin
            st_nxt.pc = bus_rdata; // see RQ1
            st_nxt.regs[csc_pkg::IDX_STACK] =
              st_r.regs[csc_pkg::IDX_STACK] + csc_pkg::WORD_STEP;
            st_nxt.step = csc_pkg::ST_NEXT;
          end
          csc_pkg::ST_MOV_RD: begin
            st_nxt.req = mk_req(st_r.regs[csc_pkg::IDX_SRC], 16'h0000,
                                1'b0, 1'b0); // see RQ9
            st_nxt.regs[csc_pkg::IDX_SRC] = st_r.regs[csc_pkg::IDX_SRC] +
                                            csc_pkg::BYTE_STEP;
            st_nxt.go = 1'b1;
            st_nxt.step = csc_pkg::ST_WAIT;
            st_nxt.ret = csc_pkg::ST_MOV_WR;
          end
          csc_pkg::ST_MOV_WR: begin
            st_nxt.req = mk_req(st_r.regs[csc_pkg::IDX_DST], bus_rdata,
                                1'b1, 1'b0); // see RQ9
            st_nxt.go = 1'b1;
            st_nxt.step = csc_pkg::ST_WAIT;
            st_nxt.ret = csc_pkg::ST_MOV_CNT;
          end
          csc_pkg::ST_MOV_CNT: begin
            st_nxt.regs[csc_pkg::IDX_DST] = st_r.regs[csc_pkg::IDX_DST] +
                                            csc_pkg::BYTE_STEP;
            st_nxt.regs[csc_pkg::IDX_CNT][7:0] =
              st_r.regs[csc_pkg::IDX_CNT][7:0] - csc_pkg::COUNT_STEP;
            st_nxt.step = (st_nxt.regs[csc_pkg::IDX_CNT][7:0] == 8'h00)
                        ? csc_pkg::ST_NEXT : csc_pkg::ST_MOV_RD; // see RQ9
          end
          csc_pkg::ST_NEXT: begin
            // Interrupts are only taken between instructions
            if (irq_take) begin
              st_nxt.cpu = csc_pkg::CPU_EXC; // see RQ18
              st_nxt.step = csc_pkg::ST_PUSH_PC;
              st_nxt.vec = i_irq_vec;
              st_nxt.ack = 1'b1;
            end else begin
              st_nxt.step = csc_pkg::ST_FETCH; // see RQ10, RQ15
            end
          end
          csc_pkg::ST_PUSH_PC: begin
            st_nxt.regs[csc_pkg::IDX_STACK] =
              st_r.regs[csc_pkg::IDX_STACK] - csc_pkg::WORD_STEP;
            st_nxt.req = mk_req(st_nxt.regs[csc_pkg::IDX_STACK], st_r.pc,
                                1'b1, 1'b1); // see RQ19
            st_nxt.go = 1'b1;
            st_nxt.step = csc_pkg::ST_WAIT;
            st_nxt.ret = csc_pkg::ST_PUSH_CCR;
          end
          csc_pkg::ST_PUSH_CCR: begin
            // Flags go in both bytes so the pop reads the upper lane
            st_nxt.regs[csc_pkg::IDX_STACK] =
              st_r.regs[csc_pkg::IDX_STACK] - csc_pkg::WORD_STEP;
            st_nxt.req = mk_req(st_nxt.regs[csc_pkg::IDX_STACK],
                                {st_r.flags, st_r.flags},
                                1'b1, 1'b1); // see RQ19
            st_nxt.go = 1'b1;
            st_nxt.step = csc_pkg::ST_WAIT;
            st_nxt.ret = csc_pkg::ST_VEC;
          end
          csc_pkg::ST_VEC: begin
            st_nxt.flags[csc_pkg::FLAG_MASK_BIT] = 1'b1;
            st_nxt.req = mk_req(st_r.vec, 16'h0000, 1'b0, 1'b1);
            st_nxt.go = 1'b1;
            st_nxt.step = csc_pkg::ST_WAIT;
            st_nxt.ret = csc_pkg::ST_VEC_LD;
          end
          csc_pkg::ST_VEC_LD: begin
            st_nxt.pc = bus_rdata;
            st_nxt.cpu = csc_pkg::CPU_EXEC; // see RQ18
            st_nxt.step = csc_pkg::ST_FETCH;
          end
          default: st_nxt.step = csc_pkg::ST_FETCH;
        endcase
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_r <= '0; // see RQ14
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_irq_ack = st_r.ack;
  assign o_cpu_state = st_r.cpu;
  assign o_halt_mode = st_r.hmode;
  assign o_clk_sub = st_r.clk_sub;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  logic dec;
  assign dec = st_r.cpu == csc_pkg::CPU_EXEC &&
               st_r.step == csc_pkg::ST_DECODE;

  a_flag_and: assert property (dec && dop == csc_pkg::OP_FLAG_AND // see RQ5
    |=> st_r.flags == ($past(st_r.flags) & $past(darg)))
    else $error("flag AND wrong");
  a_flag_or: assert property (dec && dop == csc_pkg::OP_FLAG_OR // see RQ6
    |=> st_r.flags == ($past(st_r.flags) | $past(darg)))
    else $error("flag OR wrong");
  a_flag_xor: assert property (dec && dop == csc_pkg::OP_FLAG_XOR // see RQ7
    |=> st_r.flags == ($past(st_r.flags) ^ $past(darg)))
    else $error("flag XOR wrong");
  a_flag_load: assert property (dec // see RQ3
    && dop == csc_pkg::OP_FLAG_LOAD_IMM |=> st_r.flags == $past(darg))
    else $error("flag load wrong");
  a_idle_keeps: assert property (dec // see RQ8
    && dop == csc_pkg::OP_NO_OPERATION
    |=> $stable(st_r.flags) && $stable(st_r.pc) && $stable(st_r.regs))
    else $error("no-operation changed state");
  a_ret_flags: assert property (st_r.step == csc_pkg::ST_RET_FLAGS // see RQ1
    |=> st_r.flags == $past(bus_rdata[15:8]))
    else $error("exception return flags wrong");
  a_sleep_halt: assert property (dec && dop == csc_pkg::OP_SLEEP // see RQ2
    |=> st_r.cpu == csc_pkg::CPU_HALT)
    else $error("power-down did not halt");
  a_copy_zero: assert property (dec // see RQ10
    && dop == csc_pkg::OP_BLOCK_COPY
    && st_r.regs[csc_pkg::IDX_CNT][7:0] == 8'h00
    |=> st_r.step == csc_pkg::ST_NEXT && $stable(st_r.regs))
    else $error("zero-count copy moved data");
  a_copy_count: assert property (st_r.step == csc_pkg::ST_MOV_CNT // see RQ9
    |=> st_r.regs[csc_pkg::IDX_CNT][7:0] ==
        $past(st_r.regs[csc_pkg::IDX_CNT][7:0]) - 8'h01
    && st_r.regs[csc_pkg::IDX_DST] ==
        $past(st_r.regs[csc_pkg::IDX_DST]) + 16'h0001)
    else $error("copy count or pointer wrong");
  a_irq_stack: assert property (st_r.ack // see RQ19
    |=> st_r.req.we && st_r.req.word && st_r.req.wdata == $past(st_r.pc)
    && st_r.req.addr == $past(st_r.regs[csc_pkg::IDX_STACK]) - 16'h0002)
    else $error("interrupt entry did not push PC");
  c_copy_loop: cover property (st_r.step == csc_pkg::ST_MOV_CNT
    ##1 st_r.step == csc_pkg::ST_MOV_RD);
  c_irq_entry: cover property (st_r.ack);
  c_exc_return: cover property (st_r.step == csc_pkg::ST_RET_PC);
  c_wake: cover property (st_r.cpu == csc_pkg::CPU_HALT
    ##1 st_r.cpu == csc_pkg::CPU_EXC);

endmodule

`default_nettype wire

// ### csc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module csc_mem_model (
  // Clock
  input wire logic i_ref_clk,
  // Internal bus
  input wire csc_pkg::csc_bus_t i_bus,
  output logic [15:0] o_rdata
);
  logic [7:0] mem [0:65535];
  logic [15:0] last_r;
  logic [15:0] ev;
  logic [15:0] od;

  assign ev = {i_bus.addr[15:1], 1'b0};
  assign od = {i_bus.addr[15:1], 1'b1};

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Byte read shows on both lanes; word is big-endian
  // Idle bus shows the inverse of the last value, never a stale match
  always_comb begin
    if (i_bus.rd && i_bus.word) begin
      o_rdata = {mem[ev], mem[od]};
    end else if (i_bus.rd) begin
      o_rdata = {mem[i_bus.addr], mem[i_bus.addr]};
    end else begin
      o_rdata = ~last_r;
    end
  end

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  // Data held through the last state, so a repeated write is harmless
  always @(posedge i_ref_clk) begin
    if (i_bus.rd) begin
      last_r <= o_rdata;
    end
    if (i_bus.wr && i_bus.word) begin
      mem[ev] <= i_bus.wdata[15:8];
      mem[od] <= i_bus.wdata[7:0];
    end else if (i_bus.wr) begin
      mem[i_bus.addr] <= i_bus.wdata[7:0];
    end
  end
endmodule
`default_nettype wire

// ### csc_pkg.sv
package csc_pkg;

  // ----------------------------------------------------------------
  // Instruction opcodes (upper byte of the instruction word)
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_NO_OPERATION = 8'h00;
  localparam logic [7:0] OP_SLEEP = 8'h01;
  localparam logic [7:0] OP_FLAG_STORE = 8'h02;
  localparam logic [7:0] OP_FLAG_LOAD_REG = 8'h03;
  localparam logic [7:0] OP_FLAG_OR = 8'h04;
  localparam logic [7:0] OP_FLAG_XOR = 8'h05;
  localparam logic [7:0] OP_FLAG_AND = 8'h06;
  localparam logic [7:0] OP_FLAG_LOAD_IMM = 8'h07;
  localparam logic [7:0] OP_EXC_RETURN = 8'h56;
  localparam logic [7:0] OP_BLOCK_COPY = 8'h7b;

  // ----------------------------------------------------------------
  // Architectural constants
  // ----------------------------------------------------------------
  localparam logic [15:0] PC_STEP = 16'h0002;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [7:0] COUNT_STEP = 8'h01;
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam int FLAG_MASK_BIT = 7;
  localparam logic [2:0] IDX_STACK = 3'h7;
  localparam logic [2:0] IDX_SRC = 3'h5;
  localparam logic [2:0] IDX_DST = 3'h6;
  localparam logic [2:0] IDX_CNT = 3'h4;

  // ----------------------------------------------------------------
  // Internal bus map and cycle lengths
  // ----------------------------------------------------------------
  localparam logic [15:0] IO_BASE = 16'hff80;
  localparam logic [15:0] SLOW0_LO = 16'hff98;
  localparam logic [15:0] SLOW0_HI = 16'hff9f;
  localparam logic [15:0] SLOW1_LO = 16'hffa8;
  localparam logic [15:0] SLOW1_HI = 16'hffaf;
  localparam logic [1:0] STATES_FAST = 2'h2;
  localparam logic [1:0] STATES_SLOW = 2'h3;
  localparam logic [1:0] STATE_FIRST = 2'h1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CPU_RESET, CPU_EXEC, CPU_HALT, CPU_EXC
  } csc_cpu_t;

  typedef enum logic [2:0] {
    HALT_SLEEP_HI, HALT_SLEEP_MED, HALT_STANDBY, HALT_WATCH, HALT_SUBSLEEP
  } csc_halt_t;

  typedef enum logic [1:0] {
    RUN_ACTIVE_HI, RUN_ACTIVE_MED, RUN_SUBACTIVE
  } csc_run_t;

  typedef enum logic [3:0] {
    ST_FETCH, ST_WAIT, ST_DECODE, ST_NEXT, ST_RET_FLAGS, ST_RET_PC,
    ST_MOV_RD, ST_MOV_WR, ST_MOV_CNT, ST_PUSH_PC, ST_PUSH_CCR,
    ST_VEC, ST_VEC_LD
  } csc_step_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic we;
    logic word;
  } csc_breq_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic rd;
    logic wr;
    logic word;
    logic periph;
  } csc_bus_t;

endpackage

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) chk(32'(a), 32'(b))

module testbench;
  logic i_ref_clk;
  logic i_srst;
  logic i_irq_req;
  logic [15:0] i_irq_vec;
  logic [15:0] rdata;
  logic o_irq_ack;
  logic o_clk_sub;
  csc_pkg::csc_run_t i_run_mode;
  csc_pkg::csc_halt_t i_halt_mode;
  csc_pkg::csc_cpu_t o_cpu_state;
  csc_pkg::csc_halt_t o_halt_mode;
  csc_pkg::csc_bus_t bus;
  int error_cnt = 0;
  int checks = 0;
  int n = 0;
  int dur = 0;
  logic [15:0] c_addr [0:255];
  logic [7:0] c_data [0:255];
  logic c_wr [0:255];

  csc_core i_dut (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_bus_rdata(rdata),
    .o_bus(bus), .i_irq_req(i_irq_req), .i_irq_vec(i_irq_vec),
    .o_irq_ack(o_irq_ack), .i_run_mode(i_run_mode),
    .i_halt_mode(i_halt_mode), .o_cpu_state(o_cpu_state),
    .o_halt_mode(o_halt_mode), .o_clk_sub(o_clk_sub)
  );
  csc_mem_model i_mem (.i_ref_clk(i_ref_clk), .i_bus(bus), .o_rdata(rdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  // ----------------------------------------------------------------
  // Bus monitor: logs each cycle and checks its length and stability
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (bus.rd || bus.wr) begin
      if (dur == 0) begin
        c_addr[n] = bus.addr;
        c_data[n] = bus.wdata[7:0];
        c_wr[n] = bus.wr;
        if (bus.addr >= csc_pkg::IO_BASE) `CHK(bus.word, 1'b0);
        `CHK(bus.periph, bus.addr >= csc_pkg::IO_BASE);
      end else begin
        `CHK(bus.addr, c_addr[n]);
      end
      dur++;
    end else if (dur != 0) begin
      if ((c_addr[n] >= csc_pkg::SLOW0_LO && c_addr[n] <= csc_pkg::SLOW0_HI)
          || (c_addr[n] >= csc_pkg::SLOW1_LO
          && c_addr[n] <= csc_pkg::SLOW1_HI)) begin
        `CHK(dur, 3);
      end else begin
        `CHK(dur, 2);
      end
      dur = 0;
      n++;
    end
  end

  task automatic wait_state(input csc_pkg::csc_cpu_t s);
    int k;
    for (k = 0; k < 400 && o_cpu_state !== s; k++) @(posedge i_ref_clk);
    `CHK(o_cpu_state, s);
  endtask

  // Flag ops build the count 2, copy moves two bytes, zero count moves none
  task automatic t_flags_copy();
    int k;
    int w;
    wait_state(csc_pkg::CPU_HALT);
    `CHK(c_addr[0], 16'h0000);
    w = 0;
    for (k = 0; k < n; k++) begin
      if (c_wr[k] === 1'b1) begin
        `CHK(c_addr[k], w);
        `CHK(c_data[k], (w == 0) ? 8'h01 : 8'h00);
        w++;
      end
    end
    `CHK(w, 2);
  endtask

  task automatic t_halt();
    `CHK(o_halt_mode, csc_pkg::HALT_SUBSLEEP);
    `CHK(o_clk_sub, 1'b1);
  endtask

  // Interrupt wakes the halted core and stacks PC then flags
  task automatic t_irq();
    int k;
    int m;
    m = n;
    i_irq_req <= 1'b1;
    for (k = 0; k < 50 && o_irq_ack !== 1'b1; k++) @(posedge i_ref_clk);
    `CHK(o_irq_ack, 1'b1);
    i_irq_req <= 1'b0;
    wait_state(csc_pkg::CPU_EXEC);
    repeat (4) @(posedge i_ref_clk);
    `CHK(o_clk_sub, 1'b0);
    `CHK(c_addr[m], 16'hfffe);
    `CHK(c_addr[m + 1], 16'hfffc);
    `CHK(c_data[m + 1], 8'h02);
    `CHK(c_addr[m + 2], 16'hff98);
  endtask

  initial begin
    logic [7:0] prog [0:19];
    int k;
    prog = '{8'h07, 8'h33, 8'h06, 8'h0f, 8'h04, 8'h04, 8'h05, 8'h05,
      8'h02, 8'h0c, 8'h7b, 8'h00, 8'h00, 8'h00, 8'h7b, 8'h00,
      8'h01, 8'h00, 8'h00, 8'h00};
    for (k = 0; k < 65536; k++) i_mem.mem[k] = 8'h00;
    i_mem.mem[0] = 8'h01;
    for (k = 0; k < 20; k++) i_mem.mem[16'h0100 + k] = prog[k];
    i_srst = 1'b1;
    i_irq_req = 1'b0;
    i_irq_vec = 16'hff98;
    i_run_mode = csc_pkg::RUN_ACTIVE_HI;
    i_halt_mode = csc_pkg::HALT_SUBSLEEP;
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    t_flags_copy();
    t_halt();
    t_irq();
    close_out();
  end

  initial begin
    #400000;
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
